// [rtl/stc_timer.v]
// Purpose: Sixteen-bit timer/counter with prescaler and APB registers
// Assumes: One pclk cycle is one instruction cycle
// Notes: Zero-wait writes, one wait state on reads
// Operation
// (R01) Wide-access bit on: counter read and written as one 16-bit unit.
// (R02) CCP clock select: 1x this timer both, 01 unit two, 00 companion both.
// (R03) Prescale field divides count clock by 1, 2, 4 or 8.
// (R04) External source: synchronised unless sync-disable bit is set.
// (R05) Internal source selected: sync-disable ignored, internal clock counted.
// (R06) External source counts rising edges after the first falling edge.
// (R07) Internal source advances once per instruction cycle.
// (R08) Run bit set lets counter advance; cleared stops it.
// (R09) Companion oscillator on: its port pins forced inputs, read as zero.
// (R10) Wide mode: low byte read copies live high byte to buffer.
// (R11) Wide mode: high write loads buffer; low write moves buffer in.
// (R12) Wide mode: high-byte accesses only reach the buffer.
// (R13) Low byte write clears prescaler; high byte write does not.
// (R14) Software enables companion oscillator and external source to use it.
// (R15) Software avoids unsynchronised mode when system clock comes from timer.
// (R16) Counter counts 0000h to FFFFh and wraps to 0000h.
// (R17) Overflow sets latched flag; interrupt only while enable bit set.
// (R18) Compare unit two in mode 1011 special event resets counter.
// (R19) Software write in same cycle as special event wins.
// (R20) Special event reset never sets overflow flag.
// (R21) Flag set on the wrapping step, held until software clears it.
`timescale 1ns/1ns
`include "stc_consts.vh"

module stc_timer #(
    parameter COUNT_W = 16,
    parameter PRE_W = 3
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ext_clock_pin,
    input wire companion_osc_clk,
    input wire companion_osc_enable,
    input wire [3:0] compare_two_mode,
    input wire compare_two_match,
    input wire [1:0] port_c_pin,
    input wire [1:0] port_c_direction,
    output wire [1:0] port_c_read,
    output wire [1:0] port_c_drive_en,
    output wire ccp_one_uses_this,
    output wire ccp_two_uses_this,
    output reg [COUNT_W-1:0] count_value,
    output wire overflow_irq
);

    reg [7:0] timer_three_control;
    reg [7:0] high_buffer;
    reg overflow_flag;
    reg overflow_irq_enable;
    reg ext_s1;
    reg ext_s2;
    reg ext_s3;
    reg ext_level;
    reg ext_prev;
    reg fall_seen;
    reg [PRE_W-1:0] pre_count;
    reg rd_done;

    wire wide_access_enable;
    wire ccp_clock_select_hi;
    wire ccp_clock_select_lo;
    wire [1:0] input_prescale;
    wire ext_sync_disable;
    wire clock_source_select;
    wire counter_run;
    wire ext_src;
    wire ext_now;
    wire ext_rise;
    wire ext_fall;
    wire raw_tick;
    wire [PRE_W-1:0] pre_limit;
    wire pre_tick;
    wire wr_fire;
    wire rd_fire;
    wire rd_load;
    wire mapped;
    wire wr_low;
    wire wr_high;
    wire rd_low;
    wire sev;
    wire step;
    wire wrap;

    // Address decode shared by read and write paths
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `STC_ADDR_CTRL) || (a == `STC_ADDR_LOW) ||
                (a == `STC_ADDR_HIGH) || (a == `STC_ADDR_FLAGS) ||
                (a == `STC_ADDR_ENABLES);
        end
    endfunction

    // Prescale code to terminal count
    function [PRE_W-1:0] pre_last;
        input [1:0] code;
        begin
            case (code)
                2'h0: pre_last = 3'h0; // [R03]
                2'h1: pre_last = 3'h1; // [R03]
                2'h2: pre_last = 3'h3; // [R03]
                default: pre_last = 3'h7; // [R03]
            endcase
        end
    endfunction

    assign wide_access_enable = timer_three_control[`STC_BIT_WIDE];
    assign ccp_clock_select_hi = timer_three_control[`STC_BIT_CCP_HI];
    assign ccp_clock_select_lo = timer_three_control[`STC_BIT_CCP_LO];
    assign input_prescale = {timer_three_control[`STC_BIT_PRE_HI],
        timer_three_control[`STC_BIT_PRE_LO]};
    assign ext_sync_disable = timer_three_control[`STC_BIT_NOSYNC];
    assign clock_source_select = timer_three_control[`STC_BIT_EXTSRC];
    assign counter_run = timer_three_control[`STC_BIT_RUN];

    // Capture/compare clock routing
    assign ccp_two_uses_this = ccp_clock_select_hi | ccp_clock_select_lo; // [R02]
    assign ccp_one_uses_this = ccp_clock_select_hi; // [R02]

    // Companion oscillator takes over its two port pins
    assign port_c_read = companion_osc_enable ? 2'h0 : port_c_pin; // [R09]
    assign port_c_drive_en = companion_osc_enable ? 2'h0 : ~port_c_direction; // [R09]

    // External source: oscillator when enabled, else the pin
    assign ext_src = companion_osc_enable ? companion_osc_clk : ext_clock_pin;

    // Filtered synchronised level or faster unfiltered synchroniser level
    assign ext_now = ext_sync_disable ? ext_s2 : ext_level; // [R04]
    assign ext_rise = ext_now & ~ext_prev;
    assign ext_fall = ~ext_now & ext_prev;

    // Count source before the prescaler
    assign raw_tick = clock_source_select ? (ext_rise & fall_seen) : 1'b1; // [R05] [R06] [R07]

    assign pre_limit = pre_last(input_prescale);
    assign pre_tick = raw_tick && (pre_count == pre_limit); // [R03]

    // APB decode
    assign mapped = is_mapped(paddr);
    assign wr_fire = psel & penable & pwrite & clk_en;
    assign rd_load = psel & penable & ~pwrite & ~rd_done & clk_en;
    assign rd_fire = psel & penable & ~pwrite & rd_done & clk_en;
    assign pready = clk_en & (pwrite | rd_done);
    assign pslverr = pready & psel & penable & ~mapped;
    assign wr_low = wr_fire && (paddr == `STC_ADDR_LOW);
    assign wr_high = wr_fire && (paddr == `STC_ADDR_HIGH);
    assign rd_low = rd_load && (paddr == `STC_ADDR_LOW);

    // Special event from compare unit two
    assign sev = compare_two_match && (compare_two_mode == `STC_SEV_MODE); // [R18]

    assign step = counter_run & pre_tick; // [R08]
    assign wrap = step && (count_value == `STC_COUNT_MAX); // [R16]

    assign overflow_irq = overflow_flag & overflow_irq_enable; // [R17]

    // External input synchroniser and stable-level filter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            ext_level <= 1'b0;
            ext_prev <= 1'b0;
        end else if (clk_en) begin
            ext_s1 <= ext_src;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_s2 == ext_s3) begin
                ext_level <= ext_s3; // [R04]
            end
            ext_prev <= ext_now;
        end
    end

    // Arm on first falling edge of the external source
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_seen <= 1'b0;
        end else if (clk_en) begin
            if (!clock_source_select) begin
                fall_seen <= 1'b0; // [R06]
            end else if (ext_fall) begin
                fall_seen <= 1'b1; // [R06]
            end
        end
    end

    // Prescaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_count <= {PRE_W{1'b0}};
        end else if (clk_en) begin
            if (wr_low) begin
                pre_count <= {PRE_W{1'b0}}; // [R13]
            end else if (pre_tick) begin
                pre_count <= {PRE_W{1'b0}}; // [R03]
            end else if (raw_tick && counter_run) begin
                pre_count <= pre_count + 3'h1; // [R03]
            end
        end
    end

    // Counter pair with write, special event and increment
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= `STC_COUNT_RESET;
        end else if (clk_en) begin
            if (wr_low) begin
                if (wide_access_enable) begin
                    count_value <= {high_buffer, pwdata[7:0]}; // [R01] [R11] [R19]
                end else begin
                    count_value[7:0] <= pwdata[7:0]; // [R01] [R19]
                end
            end else if (wr_high) begin
                if (!wide_access_enable) begin
                    count_value[15:8] <= pwdata[7:0]; // [R01] [R19]
                end
            end else if (sev) begin
                count_value <= `STC_COUNT_RESET; // [R18] [R20]
            end else if (step) begin
                count_value <= count_value + 16'h0001; // [R16] [R07]
            end
        end
    end

    // High byte buffer for wide access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_buffer <= 8'h00;
        end else if (clk_en) begin
            if (wr_high && wide_access_enable) begin
                high_buffer <= pwdata[7:0]; // [R11] [R12]
            end else if (rd_low && wide_access_enable) begin
                high_buffer <= count_value[15:8]; // [R10]
            end
        end
    end

    // Overflow flag; a set beats a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
        end else if (clk_en) begin
            if (wrap && !wr_low && !wr_high && !sev) begin
                overflow_flag <= 1'b1; // [R17] [R21] [R20]
            end else if (wr_fire && paddr == `STC_ADDR_FLAGS) begin
                overflow_flag <= pwdata[`STC_BIT_OVF]; // [R21]
            end
        end
    end

    // Control and enable registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_three_control <= `STC_CTRL_RESET;
            overflow_irq_enable <= 1'b0;
        end else if (clk_en) begin
            if (wr_fire && paddr == `STC_ADDR_CTRL) begin
                timer_three_control <= pwdata[7:0];
            end
            if (wr_fire && paddr == `STC_ADDR_ENABLES) begin
                overflow_irq_enable <= pwdata[`STC_BIT_OVF]; // [R17]
            end
        end
    end

    // Read data, loaded in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            rd_done <= 1'b0;
        end else if (clk_en) begin
            if (rd_fire) begin
                rd_done <= 1'b0;
            end else if (rd_load) begin
                rd_done <= 1'b1;
                case (paddr)
                    `STC_ADDR_CTRL: prdata <= {24'h000000, timer_three_control};
                    `STC_ADDR_LOW: prdata <= {24'h000000, count_value[7:0]};
                    `STC_ADDR_HIGH: begin
                        if (wide_access_enable) begin
                            prdata <= {24'h000000, high_buffer}; // [R12]
                        end else begin
                            prdata <= {24'h000000, count_value[15:8]}; // [R01]
                        end
                    end
                    `STC_ADDR_FLAGS: prdata <= {30'h00000000, overflow_flag, 1'b0};
                    `STC_ADDR_ENABLES: prdata <= {30'h00000000, overflow_irq_enable, 1'b0};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// [pkg/stc_consts.vh]
// Purpose: Constants for the sixteen-bit timer/counter
// Assumes: APB byte addresses, one register per aligned word
// Notes: Narrow registers sit in the low bits, upper bits read zero
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH

// Register byte addresses
`define STC_ADDR_CTRL 8'h00
`define STC_ADDR_LOW 8'h04
`define STC_ADDR_HIGH 8'h08
`define STC_ADDR_FLAGS 8'h0c
`define STC_ADDR_ENABLES 8'h10

// Control register fields
`define STC_BIT_WIDE 7
`define STC_BIT_CCP_HI 6
`define STC_BIT_PRE_HI 5
`define STC_BIT_PRE_LO 4
`define STC_BIT_CCP_LO 3
`define STC_BIT_NOSYNC 2
`define STC_BIT_EXTSRC 1
`define STC_BIT_RUN 0

// Flag and enable registers
`define STC_BIT_OVF 1

// Reset values and count maximum
`define STC_CTRL_RESET 8'h00
`define STC_COUNT_RESET 16'h0000
`define STC_COUNT_MAX 16'hffff

// Compare mode that fires the special event
`define STC_SEV_MODE 4'hb

`endif

// [testbench/stc_timer_chk.sv]
// Purpose: Port assertions for the timer
// Assumes: A write completes with pready high
// Notes: Mirrors control and high buffer
`timescale 1ns/1ns
module stc_chk #(
    parameter COUNT_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire companion_osc_enable,
    input wire [3:0] compare_two_mode,
    input wire compare_two_match,
    input wire [1:0] port_c_read,
    input wire ccp_one_uses_this,
    input wire ccp_two_uses_this,
    input wire [COUNT_W-1:0] count_value,
    input wire overflow_irq
);
    reg [7:0] ctrl;
    reg [7:0] hbuf;
    wire wr = psel & penable & pwrite & pready;
    wire wlow = wr && paddr == 8'h04;
    wire whigh = wr && paddr == 8'h08;
    wire sev = compare_two_match && compare_two_mode == 4'hb;
    wire [15:0] wide = {hbuf, pwdata[7:0]};
    wire [1:0] ccp_exp = {ctrl[6], ctrl[6] | ctrl[3]};
    wire tick = clk_en && ctrl[1:0] == 2'b01 && ctrl[5:4] == 2'b00 && !wlow && !whigh && !sev;
    wire halt = clk_en && !ctrl[0] && !wlow && !whigh && !sev;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 8'h00;
            hbuf <= 8'h00;
        end else begin
            if (wr && paddr == 8'h00)
                ctrl <= pwdata[7:0];
            if (whigh)
                hbuf <= pwdata[7:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    osc_read_a: assert property (companion_osc_enable |-> port_c_read == 2'b00)
        else $error("port read not zero");
    ccp_sel_a: assert property ({ccp_one_uses_this, ccp_two_uses_this} == ccp_exp)
        else $error("clock select wrong");
    tick_count_a: assert property (tick |=> count_value == $past(count_value) + 1'b1)
        else $error("no internal tick");
    halt_a: assert property (halt |=> $stable(count_value))
        else $error("stopped counter moved");
    sev_clear_a: assert property (clk_en && sev && !wlow && !whigh |=> count_value == 16'h0000)
        else $error("event did not clear");
    wide_load_a: assert property (wlow && ctrl[7] |=> count_value == $past(wide))
        else $error("wide load wrong");
    wide_hold_a: assert property (whigh && ctrl[7] && !ctrl[0] && !sev |=> $stable(count_value))
        else $error("wide high write reached counter");
    flag_hold_a: assert property (overflow_irq && !(wr && paddr > 8'h0b) |=> overflow_irq)
        else $error("flag dropped");
    sev_c: cover property (sev);
    ovf_c: cover property ($rose(overflow_irq));
    wide_c: cover property (wlow && ctrl[7]);
endmodule

bind stc_timer stc_chk #(.COUNT_W(COUNT_W)) i_stc_chk (.*);

// [testbench/stc_far_end.sv]
// Purpose: Far side: external clocks and compare unit two
// Assumes: Driven right after pclk edges
// Notes: Clocks stand low between frames
`timescale 1ns/1ns
module stc_far_end (
    input wire pclk,
    output reg ext_clock_pin,
    output reg companion_osc_clk,
    output reg [3:0] compare_two_mode,
    output reg compare_two_match
);
    integer i;
    initial begin
        ext_clock_pin = 1'b0;
        companion_osc_clk = 1'b0;
        compare_two_mode = 4'h0;
        compare_two_match = 1'b0;
    end
    task pulses(input integer n, input osc);
        for (i = 0; i < n; i = i + 1) begin
            repeat (5) @(posedge pclk);
            {companion_osc_clk, ext_clock_pin} <= {osc, !osc};
            repeat (5) @(posedge pclk);
            {companion_osc_clk, ext_clock_pin} <= 2'b00;
        end
    endtask
    task fire(input [3:0] mode);
        compare_two_mode <= mode;
        compare_two_match <= 1'b1;
        @(posedge pclk);
        compare_two_match <= 1'b0;
    endtask
endmodule

// [testbench/tb.sv]
// Purpose: Self-checking bench for the timer
// Assumes: APB timing as handed over
// Notes: Far side is stc_far_end
`timescale 1ns/1ns
module tb;
    reg pclk, presetn, psel, penable, pwrite, osc_en, en, err;
    wire slverr;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd;
    reg [15:0] c0;
    wire [31:0] prdata;
    wire pready, ext_pin, osc_clk, match, one_this, two_this, irq;
    wire [3:0] mode;
    wire [1:0] pread, pdrv;
    wire [15:0] count;
    integer fails, compares, k;
    stc_timer i_stc_timer (
        .pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(slverr), .ext_clock_pin(ext_pin),
        .companion_osc_clk(osc_clk), .companion_osc_enable(osc_en),
        .compare_two_mode(mode), .compare_two_match(match), .port_c_pin(2'b11),
        .port_c_direction(2'b01), .port_c_read(pread), .port_c_drive_en(pdrv),
        .ccp_one_uses_this(one_this), .ccp_two_uses_this(two_this),
        .count_value(count), .overflow_irq(irq)
    );
    stc_far_end i_stc_far_end (
        .pclk(pclk), .ext_clock_pin(ext_pin), .companion_osc_clk(osc_clk),
        .compare_two_mode(mode), .compare_two_match(match)
    );
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = slverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rchk(input [7:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task end_sim;
        $display("Checks %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fails = fails + 1;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite, osc_en} = 5'h00;
        en = 1'b1;
        err = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fails = 0;
        compares = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(8'h00, 32'h0);
        rchk(8'h14, 32'h0);
        chk(err, 1'b1);
        for (k = 0; k < 4; k = k + 1) begin
            apb(1'b1, 8'h00, {k[1], 2'b00, k[0], 3'b000});
            chk({one_this, two_this}, {k[1], k[1] | k[0]});
        end
        for (k = 0; k < 4; k = k + 1) begin
            apb(1'b1, 8'h00, {k[1:0], 4'h5});
            c0 = count;
            repeat (32) @(posedge pclk);
            chk(count - c0, 32 >> k);
        end
        apb(1'b1, 8'h00, 32'h80);
        c0 = count;
        repeat (8) @(posedge pclk);
        chk(count, c0);
        apb(1'b1, 8'h08, 32'h12);
        chk(count, c0);
        apb(1'b1, 8'h04, 32'h34);
        chk(count, 16'h1234);
        apb(1'b1, 8'h08, 32'h55);
        rchk(8'h04, 32'h34);
        rchk(8'h08, 32'h12);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h08, 32'h00);
        chk(count, 16'h0034);
        i_stc_far_end.fire(4'ha);
        @(posedge pclk);
        chk(count, 16'h0034);
        i_stc_far_end.fire(4'hb);
        @(posedge pclk);
        chk(count, 16'h0000);
        fork
            apb(1'b1, 8'h04, 32'h42);
            begin
                @(posedge pclk);
                i_stc_far_end.fire(4'hb);
            end
        join
        chk(count, 16'h0042);
        rchk(8'h0c, 32'h0);
        apb(1'b1, 8'h08, 32'hff);
        apb(1'b1, 8'h04, 32'hfd);
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h00, 32'h1);
        repeat (4) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, 8'h10, 32'h0);
        chk(irq, 1'b0);
        rchk(8'h0c, 32'h2);
        apb(1'b1, 8'h0c, 32'h0);
        rchk(8'h0c, 32'h0);
        en <= 1'b0;
        @(posedge pclk);
        c0 = count;
        repeat (8) @(posedge pclk);
        chk(count, c0);
        en <= 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h08, 32'h0);
            apb(1'b1, 8'h04, 32'h0);
            osc_en <= k[1];
            apb(1'b1, 8'h00, {k[0], 2'b11});
            chk(pread, k[1] ? 2'b00 : 2'b11);
            chk(pdrv, k[1] ? 2'b00 : 2'b10);
            i_stc_far_end.pulses(5, k[1]);
            repeat (8) @(posedge pclk);
            chk(count, 16'h0004);
        end
        end_sim;
    end
endmodule
